//--- pkg/sib_pkg.sv
package sib_pkg;
   localparam int          NUM_CH       = 8;
   localparam int          WORD_W       = 16;
   localparam int          NUM_WORDS    = 4;
   localparam int          IMAGE_W      = NUM_WORDS * WORD_W;
   // Word positions inside the flat image, data words first
   localparam int          WORD_PRIMARY = 0;
   localparam int          WORD_SECOND  = 1;
   localparam int          WORD_COMMON  = 2;
   localparam int          WORD_SHORT   = 3;
   // Filter bit index offset for the additional sensors 9..16
   localparam int          FILT_ADD_OFS = 8;
   localparam logic [7:0]  DIAG_SEL_RST = 8'hff;
   localparam logic [15:0] FILTER_RST   = 16'h0000;
   localparam logic [3:0]  BAUD_SEL_W   = 4'h4;
   localparam logic [3:0]  BAUD_SEL_500K = 4'h7;
   localparam int          NODE_W       = 7;
   localparam logic [6:0]  NODE_ID_MAX  = 7'h20;
   localparam logic [6:0]  NODE_ID_MIN  = 7'h01;
   localparam int          CLK_HZ       = 100_000_000;
   localparam int          BAUD_HZ      = 500_000;
   localparam int          BIT_CYCLES   = CLK_HZ / BAUD_HZ;
   localparam int          BIT_CNT_W    = 8;
   localparam logic [7:0]  BIT_CNT_LAST = 8'(BIT_CYCLES - 1);
endpackage : sib_pkg

//--- hdl/sib_sensor_image.sv
// Notes on behaviour
// [R1] Per-channel config bit, reset 1: secondary line carries primary diagnostic.
// [R2] Config bit 0: secondary line is extra sensor 9..16, no diagnostic.
// [R3] Primary sensor line states form the first image word.
// [R4] Secondary line data, diagnostic or extra sensor, forms the second word.
// [R5] Filter bit per input, reset 0; set to 1 ignores that input.
// [R6] Sixteen filter bits; primary ones apply at config 1, extra at 0.
// [R7] Four contiguous 16-bit words, data words before diagnostic words.
// [R8] Diagnostic bit 1 and red lamp on when secondary line lacks signal.
// [R9] Third word holds common diagnostics, 1 means problem, any config.
// [R10] Fourth word flags supply short per channel, 1 means short.
// [R11] Gateway places the words in its input block by node address.
// [R12] Node id on switches at most 32 and matching master setup.
// [R13] Link runs at 500 kbaud when baud selector sits at position 7.
// [R14] Filtered input reads 0; socket n maps to bit n-1.
`timescale 1ns/1ps
`default_nettype none
module sib_sensor_image (
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic [sib_pkg::NUM_CH-1:0]     primary_pin,
   input  wire logic [sib_pkg::NUM_CH-1:0]     secondary_pin,
   input  wire logic [sib_pkg::WORD_W-1:0]     common_fault_pin,
   input  wire logic [sib_pkg::NUM_CH-1:0]     supply_short_pin,
   input  wire logic [3:0]                     baud_sel_pin,
   input  wire logic [sib_pkg::NODE_W-1:0]     node_id_pin,
   input  wire logic                           cfg_wr,
   input  wire logic [sib_pkg::NUM_CH-1:0]     cfg_diag_sel,
   input  wire logic [sib_pkg::WORD_W-1:0]     cfg_filter,
   output logic [sib_pkg::IMAGE_W-1:0]         process_image_q,
   output logic [sib_pkg::NUM_CH-1:0]          red_led_q,
   output logic                                link_enable_q,
   output logic                                baud_tick_q,
   output logic                                node_ok_q,
   output logic [sib_pkg::NODE_W-1:0]          node_id_q
);
   import sib_pkg::*;

   // Two synchroniser stages for every field input
   logic [NUM_CH-1:0]  prim_s1_q, prim_s2_q;
   logic [NUM_CH-1:0]  sec_s1_q,  sec_s2_q;
   logic [WORD_W-1:0]  comm_s1_q, comm_s2_q;
   logic [NUM_CH-1:0]  shrt_s1_q, shrt_s2_q;
   logic [BAUD_SEL_W-1:0] baud_s1_q, baud_s2_q;
   logic [NODE_W-1:0]  node_s1_q, node_s2_q;
   logic [NUM_CH-1:0]  diag_sel_q;
   logic [WORD_W-1:0]  filter_q;
   logic [BIT_CNT_W-1:0] bit_cnt_q;
   logic [NUM_CH-1:0]  prim_word_d, sec_word_d, led_d;

   // Pins come from the field; two stages before any logic looks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prim_s1_q <= '0;
         prim_s2_q <= '0;
      end else begin
         prim_s1_q <= primary_pin;
         prim_s2_q <= prim_s1_q;
      end
   end

   // Secondary lines carry a diagnostic or an extra sensor
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sec_s1_q <= '0;
         sec_s2_q <= '0;
      end else begin
         sec_s1_q <= secondary_pin;
         sec_s2_q <= sec_s1_q;
      end
   end

   // Common faults pass unmasked; filters cover sensors only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         comm_s1_q <= '0;
         comm_s2_q <= '0;
      end else begin
         comm_s1_q <= common_fault_pin;
         comm_s2_q <= comm_s1_q;
      end
   end

   // Supply shorts are never filtered either
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shrt_s1_q <= '0;
         shrt_s2_q <= '0;
      end else begin
         shrt_s1_q <= supply_short_pin;
         shrt_s2_q <= shrt_s1_q;
      end
   end

   // Switches read live, so turning one takes effect without reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         baud_s1_q <= '0;
         baud_s2_q <= '0;
      end else begin
         baud_s1_q <= baud_sel_pin;
         baud_s2_q <= baud_s1_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         node_s1_q <= '0;
         node_s2_q <= '0;
      end else begin
         node_s1_q <= node_id_pin;
         node_s2_q <= node_s1_q;
      end
   end

   // Configuration loaded by the gateway, held until the next write
   // Written from logic on this clock, so no synchroniser here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         diag_sel_q <= DIAG_SEL_RST;                         // [R1]
         filter_q   <= FILTER_RST;                           // [R5]
      end else if (cfg_wr) begin
         diag_sel_q <= cfg_diag_sel;                         // [R2]
         filter_q   <= cfg_filter;                           // [R6]
      end
   end

   // Primary filter only counts while the channel is diagnostic
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (diag_sel_q[i]) begin
            prim_word_d[i] = prim_s2_q[i] & ~filter_q[i];    // [R6] [R14]
         end else begin
            prim_word_d[i] = prim_s2_q[i];                   // [R6]
         end
      end
   end

   // Diagnostics are not filtered; the lamp mirrors the diagnostic bit
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (diag_sel_q[i]) begin
            // Diagnostic is active low on the line
            sec_word_d[i] = ~sec_s2_q[i];                    // [R8] [R1]
            led_d[i]      = ~sec_s2_q[i];                    // [R8]
         end else begin
            // Extra sensor uses the upper half of the filter bits
            sec_word_d[i] = sec_s2_q[i]
                            & ~filter_q[i + FILT_ADD_OFS];   // [R2] [R5]
            led_d[i]      = 1'b0;                            // [R2]
         end
      end
   end

   // Image words, primary data first and diagnostics after
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         process_image_q <= '0;
      end else begin
         // Unused upper bits of words one, two and four read zero
         process_image_q[WORD_PRIMARY*WORD_W +: WORD_W] <=
            {{(WORD_W-NUM_CH){1'b0}}, prim_word_d};          // [R3] [R7]
         process_image_q[WORD_SECOND*WORD_W +: WORD_W] <=
            {{(WORD_W-NUM_CH){1'b0}}, sec_word_d};           // [R4] [R7]
         process_image_q[WORD_COMMON*WORD_W +: WORD_W] <=
            comm_s2_q;                                       // [R9]
         process_image_q[WORD_SHORT*WORD_W +: WORD_W] <=
            {{(WORD_W-NUM_CH){1'b0}}, shrt_s2_q};            // [R10] [R14]
      end
   end

   // Lamps take the same edge as the second word they mirror
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         red_led_q <= '0;
      end else begin
         red_led_q <= led_d;                                 // [R8]
      end
   end

   // Link bit-rate enable; other switch positions keep the link silent
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link_enable_q <= 1'b0;
      end else begin
         link_enable_q <= (baud_s2_q == BAUD_SEL_500K);      // [R13]
      end
   end

   // Count restarts while the link is off, so the first tick after
   // enabling comes a full bit time later, never a short one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bit_cnt_q   <= '0;
         baud_tick_q <= 1'b0;
      end else if (!link_enable_q) begin
         bit_cnt_q   <= '0;
         baud_tick_q <= 1'b0;
      end else if (bit_cnt_q == BIT_CNT_LAST) begin
         bit_cnt_q   <= '0;
         baud_tick_q <= 1'b1;                                // [R13]
      end else begin
         bit_cnt_q   <= bit_cnt_q + 1'b1;
         baud_tick_q <= 1'b0;
      end
   end

   // Node address for gateway placement; out-of-range ids are flagged
   // Id 0 is no legal node, so it is flagged like one above the limit;
   // the gateway still sees the raw id to report the misconfiguration
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         node_id_q <= '0;
         node_ok_q <= 1'b0;
      end else begin
         node_id_q <= node_s2_q;                             // [R11]
         node_ok_q <= (node_s2_q >= NODE_ID_MIN)
                      && (node_s2_q <= NODE_ID_MAX);         // [R12]
      end
   end
endmodule : sib_sensor_image
`default_nettype wire

//--- dv/sib_gateway_model.sv
`timescale 1ns/1ps
`default_nettype none
module sib_gateway_model import sib_pkg::*; (
   input  wire logic               clk,
   input  wire logic               baud_tick_q,
   input  wire logic [IMAGE_W-1:0] process_image_q,
   output logic      [WORD_W-1:0]  block_q [NUM_WORDS]
);
   // Refreshed only on a link tick, so the copy lags the device image
   always_ff @(posedge clk) begin
      if (baud_tick_q) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            block_q[i] <= process_image_q[i*WORD_W +: WORD_W];
         end
      end
   end
endmodule : sib_gateway_model
`default_nettype wire

//--- dv/sib_sensor_image_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sib_chk import sib_pkg::*; (
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                cfg_wr,
   input wire logic                link_enable_q,
   input wire logic                baud_tick_q,
   input wire logic                node_ok_q,
   input wire logic [WORD_W-1:0]   common_fault_pin,
   input wire logic [NUM_CH-1:0]   supply_short_pin,
   input wire logic [NUM_CH-1:0]   cfg_diag_sel,
   input wire logic [NUM_CH-1:0]   red_led_q,
   input wire logic [3:0]          baud_sel_pin,
   input wire logic [NODE_W-1:0]   node_id_q,
   input wire logic [IMAGE_W-1:0]  process_image_q
);
   logic [2:0] up_q;
   // Pin history is only valid once three edges have passed out of reset
   always_ff @(posedge clk) up_q <= rst_n ? {up_q[1:0], 1'b1} : 3'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_all_extra;
      cfg_wr && cfg_diag_sel == 8'h00 ##1 !cfg_wr;
   endsequence
   chk_red_diag: assert property (
      (red_led_q & ~process_image_q[23:16]) == 8'h00)
      else $error("red lamp lit without diagnostic bit");
   chk_common_word: assert property (up_q == 3'h7 |->
      process_image_q[47:32] == $past(common_fault_pin, 3)) else $error("word3");
   chk_short_word: assert property (up_q == 3'h7 |->
      process_image_q[55:48] == $past(supply_short_pin, 3)) else $error("word4");
   chk_link_sel: assert property (up_q == 3'h7 |-> link_enable_q ==
      ($past(baud_sel_pin, 3) == BAUD_SEL_500K)) else $error("link enable");
   chk_upper_zero: assert property (
      {process_image_q[63:56], process_image_q[31:24],
       process_image_q[15:8]} == 24'h0) else $error("pad");
   chk_node_range: assert property (
      node_ok_q == (node_id_q inside {[1:32]})) else $error("node range");
   chk_tick_gap: assert property (baud_tick_q |=> !baud_tick_q [*8] ##192
      (baud_tick_q || !link_enable_q)) else $error("tick spacing");
   chk_cfg_extra: assert property (s_all_extra |-> ##2 red_led_q == 8'h00)
      else $error("red lamp in extra mode");
endmodule : sib_chk
bind sib_sensor_image sib_chk i_chk (.*);
`default_nettype wire

//--- dv/tb_sixteen_channel_sensor_input_image.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sixteen_channel_sensor_input_image;
   import sib_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, link_enable_q, baud_tick_q;
   logic node_ok_q;
   logic [7:0] primary_pin = 8'h00, secondary_pin = 8'h00, red_led_q;
   logic [7:0] supply_short_pin = 8'h00, cfg_diag_sel = 8'hff, dg = 8'hff;
   logic [15:0] common_fault_pin = 16'h0000, cfg_filter = 16'h0000, fl;
   logic [3:0] baud_sel_pin = 4'h0;
   logic [6:0] node_id_pin = 7'h00, node_id_q;
   logic [63:0] process_image_q;
   logic [15:0] block_q [NUM_WORDS];
   logic [63:0] img;
   int gap;
   int num_errors = 0, check_count = 0, cyc = 0, seed = 74;
   sib_sensor_image i_dut (.*);
   sib_gateway_model i_gw (.*);
   function automatic logic [63:0] exp_img();
      logic [7:0] w1, w2;
      for (int i = 0; i < 8; i++) begin
         w1[i] = primary_pin[i] & (dg[i] ? ~fl[i] : 1'b1);
         w2[i] = dg[i] ? ~secondary_pin[i] : secondary_pin[i] & ~fl[8+i];
      end
      return {8'h0, supply_short_pin, common_fault_pin, 8'h0, w2, 8'h0, w1};
   endfunction : exp_img
   task automatic check_image();
      logic [63:0] e;
      e = exp_img();
      `CHK(process_image_q[15:0], e[15:0])
      `CHK(process_image_q[31:16], e[31:16])
      `CHK(process_image_q[47:32], e[47:32])
      `CHK(process_image_q[63:48], e[63:48])
      `CHK(red_led_q, dg & ~secondary_pin)
      `CHK(node_ok_q, 1'(node_id_pin inside {[1:32]}))
      `CHK(node_id_q, node_id_pin)
   endtask : check_image
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic settle();
      repeat (5) @(posedge clk);
      #1;
   endtask : settle
   initial forever #5 clk = ~clk;
   always @(posedge clk) if (++cyc > 2000) begin num_errors++; wrap_up(); end
   initial begin
      fl = FILTER_RST;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int k = 0; k < 40; k++) begin
         {primary_pin, secondary_pin, common_fault_pin} = 32'($random(seed));
         {supply_short_pin, node_id_pin, baud_sel_pin} = 19'($random(seed));
         if (k % 8 == 4) begin
            {cfg_diag_sel, cfg_filter} = 24'($random(seed));
            if (k == 4) cfg_diag_sel = 8'h00;
            if (k == 12) cfg_filter = 16'hffff;
            cfg_wr = 1'b1;
            @(posedge clk);
            #1 cfg_wr = 1'b0;
            dg = cfg_diag_sel;
            fl = cfg_filter;
         end
         settle();
         check_image();
      end
      $display("test image and config done");
      baud_sel_pin = BAUD_SEL_500K;
      settle();
      `CHK(link_enable_q, 1'b1)
      for (int t = 0; t < 2; t++) begin
         gap = t;
         while (baud_tick_q !== 1'b1 && gap < 300) begin
            @(posedge clk) #1 gap++;
         end
         if (t == 1) `CHK(gap, BIT_CYCLES)
         @(posedge clk) #1;
         img = exp_img();
         for (int i = 0; i < NUM_WORDS; i++)
            `CHK(block_q[i], img[i*WORD_W +: WORD_W])
         {primary_pin, secondary_pin, common_fault_pin} = 32'($random(seed));
      end
      baud_sel_pin = 4'h6;
      settle();
      `CHK(link_enable_q, 1'b0)
      `CHK(baud_tick_q, 1'b0)
      $display("test link and gateway done");
      rst_n = 1'b0;
      settle();
      `CHK({process_image_q, red_led_q, node_ok_q}, 73'h0)
      rst_n = 1'b1;
      dg = DIAG_SEL_RST;
      fl = FILTER_RST;
      settle();
      check_image();
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule : tb_sixteen_channel_sensor_input_image
`default_nettype wire
